// ---- rtl/dmt_timer.sv ----
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dmt_timer (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic             wb_ack_o,
    input  wire logic        count_input_pin_a_i,
    input  wire logic        count_input_pin_b_i,
    input  wire logic        external_gate_input_a_i,
    input  wire logic        external_gate_input_b_i,
    input  wire logic        ext_clk_i,
    input  wire logic        vector_taken_a_i,
    input  wire logic        vector_taken_b_i,
    output logic             overflow_flag_a_o,
    output logic             overflow_flag_b_o,
    output logic             overflow_b_pulse_o,
    output logic             irq_o
);
    // one count step for the given mode
    function automatic dmt_pkg::dmt_step_t step(input dmt_pkg::dmt_mode_t md,
                                                input logic [7:0] lo,
                                                input logic [7:0] hi);
        dmt_pkg::dmt_step_t r;
        logic [12:0] c13;
        logic [15:0] c16;
        r   = '{ovf: 1'b0, high: hi, low: lo};
        c13 = {hi, lo[4:0]};
        c16 = {hi, lo};
        unique case (md)
            dmt_pkg::DMT_MODE_13BIT:
            begin
                r.ovf  = &c13;
                c13    = c13 + 13'h0001;
                r.high = c13[12:5];
                r.low  = {lo[7:5], c13[4:0]};
            end
            dmt_pkg::DMT_MODE_16BIT:
            begin
                r.ovf  = &c16;
                c16    = c16 + 16'h0001;
                r.high = c16[15:8];
                r.low  = c16[7:0];
            end
            dmt_pkg::DMT_MODE_RELOAD:
            begin
                r.ovf = &lo;
                r.low = (&lo) ? hi : lo + 8'h01;
            end
            dmt_pkg::DMT_MODE_SPLIT:
            begin
                r.ovf = &lo;
                r.low = lo + 8'h01;
            end
        endcase
        return r;
    endfunction

    logic [7:0]       low_a_r, low_a_nxt, high_a_r, high_a_nxt;
    logic [7:0]       low_b_r, low_b_nxt, high_b_r, high_b_nxt;
    logic [7:0]       tctl_r, tctl_nxt, mode_r, mode_nxt;
    logic [7:0]       clkctl_r, clkctl_nxt, extcfg_r, extcfg_nxt;
    logic [1:0]       irqst_r, irqst_nxt, irqmsk_r, irqmsk_nxt;
    logic [31:0]      rdat_r, rdat_nxt;
    logic             ack_r, ack_nxt, irq_r, irq_nxt, ovfp_r, ovfp_nxt;
    logic             pin_a_r, pin_b_r, eclk_r;
    logic [5:0]       div48_r, div48_nxt;
    logic [3:0]       div12_r, div12_nxt;
    logic [2:0]       div8_r, div8_nxt;
    logic             tick12, tick4, tick48, tick_ext, pres_tick;
    logic             fall_a, fall_b, clk_a, clk_b, run_a, run_b, run_h;
    logic             split_a, wr, rd;
    dmt_pkg::dmt_cfg_t  cfg_a, cfg_b;
    dmt_pkg::dmt_step_t st_a, st_b;
    logic [7:0]       high_split;
    logic             ovf_a, ovf_b, ovf_h;

    assign cfg_a   = dmt_pkg::dmt_cfg_t'(mode_r[dmt_pkg::MD_A_LSB +: 4]);
    assign cfg_b   = dmt_pkg::dmt_cfg_t'(mode_r[dmt_pkg::MD_B_LSB +: 4]);
    assign split_a = (cfg_a.mode == dmt_pkg::DMT_MODE_SPLIT);
    assign wr      = wb_cyc_i && wb_stb_i && !ack_r && wb_we_i && wb_sel_i[0];
    assign rd      = wb_cyc_i && wb_stb_i && !ack_r && !wb_we_i;

    // prescaler taps
    assign tick4    = (div48_r[1:0] == 2'(dmt_pkg::DIV_SCALE_4 - 1));
    assign tick48   = (div48_r == 6'(dmt_pkg::DIV_SCALE_48 - 1));
    assign tick12   = (div12_r == 4'(dmt_pkg::DIV_SCALE_12 - 1));
    assign tick_ext = ext_clk_i && !eclk_r && (div8_r == 3'(dmt_pkg::DIV_EXT_8 - 1));

    always_comb
    begin
        unique case (dmt_pkg::dmt_scale_t'(clkctl_r[1:0]))
            dmt_pkg::DMT_SCALE_12:   pres_tick = tick12;
            dmt_pkg::DMT_SCALE_4:    pres_tick = tick4;
            dmt_pkg::DMT_SCALE_48:   pres_tick = tick48;
            dmt_pkg::DMT_SCALE_EXT8: pres_tick = tick_ext;
        endcase
    end

    // falling edges on count pins
    assign fall_a = pin_a_r && !count_input_pin_a_i;
    assign fall_b = pin_b_r && !count_input_pin_b_i;

    // count enables per timer
    always_comb
    begin
        clk_a = cfg_a.src_pin ? fall_a : (clkctl_r[dmt_pkg::CK_SYS_A] || pres_tick);
        clk_b = (cfg_b.src_pin && !split_a) ? fall_b
              : (clkctl_r[dmt_pkg::CK_SYS_B] || pres_tick);
        run_a = tctl_r[dmt_pkg::TC_RUN_A] && (!cfg_a.gate
              || (external_gate_input_a_i == extcfg_r[dmt_pkg::EX_POL_A]));
        run_b = (split_a ? 1'b1 : tctl_r[dmt_pkg::TC_RUN_B])
              && (cfg_b.mode != dmt_pkg::DMT_MODE_SPLIT)
              && (!cfg_b.gate
              || (external_gate_input_b_i == extcfg_r[dmt_pkg::EX_POL_B]));
        run_h = split_a && tctl_r[dmt_pkg::TC_RUN_B];
    end

    always_comb
    begin
        st_a       = step(cfg_a.mode, low_a_r, high_a_r);
        st_b       = step(cfg_b.mode, low_b_r, high_b_r);
        high_split = high_a_r + 8'h01;
        ovf_a      = run_a && clk_a && st_a.ovf;
        ovf_b      = run_b && clk_b && st_b.ovf;
        ovf_h      = run_h && (clkctl_r[dmt_pkg::CK_SYS_A] || pres_tick)
                   && (&high_a_r);
    end

    // next state of all registers except pin_a_r, pin_b_r and eclk_r
    always_comb
    begin
        low_a_nxt  = low_a_r;
        high_a_nxt = high_a_r;
        low_b_nxt  = low_b_r;
        high_b_nxt = high_b_r;
        tctl_nxt   = tctl_r;
        mode_nxt   = mode_r;
        clkctl_nxt = clkctl_r;
        extcfg_nxt = extcfg_r;
        irqst_nxt  = irqst_r;
        irqmsk_nxt = irqmsk_r;
        rdat_nxt   = 32'h0000_0000;
        ack_nxt    = wb_cyc_i && wb_stb_i && !ack_r;
        div48_nxt  = tick48 ? 6'h00 : div48_r + 6'h01;
        div12_nxt  = tick12 ? 4'h0 : div12_r + 4'h1;
        div8_nxt   = (ext_clk_i && !eclk_r) ? div8_r + 3'h1 : div8_r;

        // counting; run bit never touches the count
        if (run_a && clk_a)
        begin
            low_a_nxt = st_a.low;
            if (!split_a)
            begin
                high_a_nxt = st_a.high;
            end
        end
        if (run_h && (clkctl_r[dmt_pkg::CK_SYS_A] || pres_tick))
        begin
            high_a_nxt = high_split;
        end
        if (run_b && clk_b)
        begin
            low_b_nxt  = st_b.low;
            high_b_nxt = st_b.high;
        end

        // register writes, byte lane 0
        if (wr)
        begin
            unique case (wb_adr_i)
                dmt_pkg::ADR_LOW_A:  low_a_nxt  = wb_dat_i[7:0];
                dmt_pkg::ADR_HIGH_A: high_a_nxt = wb_dat_i[7:0];
                dmt_pkg::ADR_LOW_B:  low_b_nxt  = wb_dat_i[7:0];
                dmt_pkg::ADR_HIGH_B: high_b_nxt = wb_dat_i[7:0];
                dmt_pkg::ADR_TCTL:   tctl_nxt   = wb_dat_i[7:0];
                dmt_pkg::ADR_MODE:   mode_nxt   = wb_dat_i[7:0];
                dmt_pkg::ADR_CLKCTL: clkctl_nxt = {4'h0, wb_dat_i[3:0]};
                dmt_pkg::ADR_EXTCFG: extcfg_nxt = {6'h00, wb_dat_i[1:0]};
                dmt_pkg::ADR_IRQMSK: irqmsk_nxt = wb_dat_i[1:0];
                default:             ;
            endcase
        end

        // vector taken clears its flag
        if (vector_taken_a_i)
        begin
            tctl_nxt[dmt_pkg::TC_FLAG_A] = 1'b0;
        end
        if (vector_taken_b_i)
        begin
            tctl_nxt[dmt_pkg::TC_FLAG_B] = 1'b0;
        end

        // reads; status clears on read
        if (rd)
        begin
            unique case (wb_adr_i)
                dmt_pkg::ADR_LOW_A:  rdat_nxt[7:0] = low_a_r;
                dmt_pkg::ADR_HIGH_A: rdat_nxt[7:0] = high_a_r;
                dmt_pkg::ADR_LOW_B:  rdat_nxt[7:0] = low_b_r;
                dmt_pkg::ADR_HIGH_B: rdat_nxt[7:0] = high_b_r;
                dmt_pkg::ADR_TCTL:   rdat_nxt[7:0] = tctl_r;
                dmt_pkg::ADR_MODE:   rdat_nxt[7:0] = mode_r;
                dmt_pkg::ADR_CLKCTL: rdat_nxt[7:0] = clkctl_r;
                dmt_pkg::ADR_EXTCFG: rdat_nxt[7:0] = extcfg_r;
                dmt_pkg::ADR_IRQST:
                begin
                    rdat_nxt[1:0] = irqst_r;
                    irqst_nxt     = 2'h0;
                end
                dmt_pkg::ADR_IRQMSK: rdat_nxt[1:0] = irqmsk_r;
                default:             ;
            endcase
        end

        // hardware set wins over any clear
        if (ovf_a)
        begin
            tctl_nxt[dmt_pkg::TC_FLAG_A] = 1'b1;
            irqst_nxt[dmt_pkg::IS_OVF_A] = 1'b1;
        end
        if (ovf_h || (ovf_b && !split_a))
        begin
            tctl_nxt[dmt_pkg::TC_FLAG_B] = 1'b1;
            irqst_nxt[dmt_pkg::IS_OVF_B] = 1'b1;
        end
        ovfp_nxt = ovf_b;
        irq_nxt  = |(irqst_nxt & irqmsk_nxt);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            low_a_r  <= dmt_pkg::RST_BYTE;
            high_a_r <= dmt_pkg::RST_BYTE;
            low_b_r  <= dmt_pkg::RST_BYTE;
            high_b_r <= dmt_pkg::RST_BYTE;
            tctl_r   <= dmt_pkg::RST_BYTE;
            mode_r   <= dmt_pkg::RST_BYTE;
            clkctl_r <= dmt_pkg::RST_BYTE;
            extcfg_r <= dmt_pkg::RST_BYTE;
            irqst_r  <= dmt_pkg::RST_IRQ;
            irqmsk_r <= dmt_pkg::RST_IRQ;
            rdat_r   <= 32'h0000_0000;
            ack_r    <= 1'b0;
            irq_r    <= 1'b0;
            ovfp_r   <= 1'b0;
            pin_a_r  <= 1'b1;
            pin_b_r  <= 1'b1;
            eclk_r   <= 1'b1;
            div48_r  <= 6'h00;
            div12_r  <= 4'h0;
            div8_r   <= 3'h0;
        end
        else
        begin
            low_a_r  <= low_a_nxt;
            high_a_r <= high_a_nxt;
            low_b_r  <= low_b_nxt;
            high_b_r <= high_b_nxt;
            tctl_r   <= tctl_nxt;
            mode_r   <= mode_nxt;
            clkctl_r <= clkctl_nxt;
            extcfg_r <= extcfg_nxt;
            irqst_r  <= irqst_nxt;
            irqmsk_r <= irqmsk_nxt;
            rdat_r   <= rdat_nxt;
            ack_r    <= ack_nxt;
            irq_r    <= irq_nxt;
            ovfp_r   <= ovfp_nxt;
            pin_a_r  <= count_input_pin_a_i;
            pin_b_r  <= count_input_pin_b_i;
            eclk_r   <= ext_clk_i;
            div48_r  <= div48_nxt;
            div12_r  <= div12_nxt;
            div8_r   <= div8_nxt;
        end
    end

    assign wb_dat_o           = rdat_r;
    assign wb_ack_o           = ack_r;
    assign overflow_flag_a_o  = tctl_r[dmt_pkg::TC_FLAG_A];
    assign overflow_flag_b_o  = tctl_r[dmt_pkg::TC_FLAG_B];
    assign overflow_b_pulse_o = ovfp_r;
    assign irq_o              = irq_r;
endmodule
`default_nettype wire

// ---- rtl/dmt_pkg.sv ----
`default_nettype none
package dmt_pkg;
    // byte addresses on the register bus
    localparam logic [7:0] ADR_LOW_A  = 8'h80;
    localparam logic [7:0] ADR_HIGH_A = 8'h84;
    localparam logic [7:0] ADR_TCTL   = 8'h88;
    localparam logic [7:0] ADR_MODE   = 8'h8C;
    localparam logic [7:0] ADR_LOW_B  = 8'h90;
    localparam logic [7:0] ADR_HIGH_B = 8'h94;
    localparam logic [7:0] ADR_CLKCTL = 8'h98;
    localparam logic [7:0] ADR_EXTCFG = 8'h9C;
    localparam logic [7:0] ADR_IRQST  = 8'hA0;
    localparam logic [7:0] ADR_IRQMSK = 8'hA4;

    // control register bit positions
    localparam int TC_FLAG_B = 7;
    localparam int TC_RUN_B  = 6;
    localparam int TC_FLAG_A = 5;
    localparam int TC_RUN_A  = 4;
    // mode register: timer b in [7:4], timer a in [3:0]
    localparam int MD_B_LSB  = 4;
    localparam int MD_A_LSB  = 0;
    // clock control
    localparam int CK_SYS_B  = 3;
    localparam int CK_SYS_A  = 2;
    // external input config
    localparam int EX_POL_A  = 0;
    localparam int EX_POL_B  = 1;
    // interrupt status / mask
    localparam int IS_OVF_A  = 0;
    localparam int IS_OVF_B  = 1;

    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_IRQ  = 2'h0;

    // prescaler divisors
    localparam int DIV_SCALE_12  = 12;
    localparam int DIV_SCALE_4   = 4;
    localparam int DIV_SCALE_48  = 48;
    localparam int DIV_EXT_8     = 8;

    typedef enum logic [1:0] {
        DMT_MODE_13BIT,
        DMT_MODE_16BIT,
        DMT_MODE_RELOAD,
        DMT_MODE_SPLIT
    } dmt_mode_t;

    typedef enum logic [1:0] {
        DMT_SCALE_12,
        DMT_SCALE_4,
        DMT_SCALE_48,
        DMT_SCALE_EXT8
    } dmt_scale_t;

    typedef struct packed {
        logic      gate;
        logic      src_pin;
        dmt_mode_t mode;
    } dmt_cfg_t;

    typedef struct packed {
        logic       ovf;
        logic [7:0] high;
        logic [7:0] low;
    } dmt_step_t;
endpackage
`default_nettype wire

// ---- rtl/dmt_unused_placeholder_removed.sv ----
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- verification/dmt_timer_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module dmt_timer_checker (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    input  wire logic        vector_taken_a_i,
    input  wire logic        vector_taken_b_i,
    input  wire logic        overflow_flag_a_o,
    input  wire logic        overflow_flag_b_o,
    input  wire logic        irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic       take;
    logic       hold_a;
    logic       hold_b;
    logic       ctl_wr;
    logic [1:0] mask_r;
    logic [1:0] mask_nxt;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign ctl_wr = take && wb_we_i && wb_sel_i[0] && (wb_adr_i == dmt_pkg::ADR_TCTL);
    assign hold_a = overflow_flag_a_o && !vector_taken_a_i && !ctl_wr;
    assign hold_b = overflow_flag_b_o && !vector_taken_b_i && !ctl_wr;
    // shadow of the interrupt mask
    always_comb
    begin
        mask_nxt = mask_r;
        if (take && wb_we_i && wb_sel_i[0] && (wb_adr_i == dmt_pkg::ADR_IRQMSK))
            mask_nxt = wb_dat_i[1:0];
    end
    always_ff @(posedge clk_i)
        mask_r <= rst_i ? 2'h0 : mask_nxt;
    sequence s_take;
        take;
    endsequence
    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    AST_ACK_NEXT: assert property (s_take |=> s_ack_pulse)
        else $error("ack not a single pulse after request");
    AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
        else $error("ack without request");
    AST_DAT_UPPER: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read bits not zero");
    AST_UNMAPPED: assert property (s_take ##0 (!wb_we_i && wb_adr_i == 8'h00)
        |=> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    AST_NO_STRAY_ACK: assert property (!wb_cyc_i |=> !wb_ack_o)
        else $error("ack outside a cycle");
    AST_FLAG_A_HOLD: assert property (hold_a |=> overflow_flag_a_o)
        else $error("flag a dropped by itself");
    AST_FLAG_B_HOLD: assert property (hold_b |=> overflow_flag_b_o)
        else $error("flag b dropped by itself");
    AST_IRQ_MASKED: assert property (irq_o |-> mask_r != 2'h0)
        else $error("irq with all sources masked");
endmodule
bind dmt_timer dmt_timer_checker i_dmt_timer_checker (.clk_i(clk_i), .rst_i(rst_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .vector_taken_a_i(vector_taken_a_i), .vector_taken_b_i(vector_taken_b_i),
    .overflow_flag_a_o(overflow_flag_a_o), .overflow_flag_b_o(overflow_flag_b_o), .irq_o(irq_o));
`default_nettype wire

// ---- verification/dmt_pin_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module dmt_pin_model (
    input  wire logic       clk_i,
    input  wire logic       go_i,
    input  wire logic [7:0] edges_i,
    input  wire logic [3:0] hold_i,
    output logic            pin_o,
    output logic            busy_o
);
    logic [8:0] half_r;
    logic [3:0] cnt_r;
    // burst of falling edges, idle high between bursts
    initial
    begin
        pin_o = 1'b1;
        busy_o = 1'b0;
        forever
        begin
            @(posedge clk_i);
            if (go_i && !busy_o)
            begin
                busy_o <= 1'b1;
                half_r <= {edges_i, 1'b0};
                cnt_r <= hold_i;
            end
            else if (busy_o)
            begin
                if (cnt_r > 4'h1)
                    cnt_r <= cnt_r - 4'h1;
                else if (half_r == 9'h0)
                    busy_o <= 1'b0;
                else
                begin
                    pin_o <= ~pin_o;
                    half_r <= half_r - 9'h1;
                    cnt_r <= hold_i;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- verification/dual_mode_timer_counter_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module dual_mode_timer_counter_tb;
    logic        clk, rst, cyc, stb, we, ack, ga, gb, vta, vtb, pin, busy, go, fa, fb, pb, irq;
    logic [7:0]  adr, q, edges, r0, r1, r2, r3, msk;
    logic [3:0]  hold;
    logic [31:0] dw, dr, seed;
    logic [16:0] ea, eb;
    int          failures, total_checks, n;
    dmt_timer i_dmt_timer (.clk_i(clk), .rst_i(rst), .wb_adr_i(adr), .wb_dat_i(dw),
        .wb_dat_o(dr), .wb_we_i(we), .wb_sel_i(4'h1), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_ack_o(ack), .count_input_pin_a_i(pin), .count_input_pin_b_i(pin),
        .external_gate_input_a_i(ga), .external_gate_input_b_i(gb), .ext_clk_i(pin),
        .vector_taken_a_i(vta), .vector_taken_b_i(vtb), .overflow_flag_a_o(fa),
        .overflow_flag_b_o(fb), .overflow_b_pulse_o(pb), .irq_o(irq));
    dmt_pin_model i_dmt_pin_model (.clk_i(clk), .go_i(go), .edges_i(edges), .hold_i(hold),
        .pin_o(pin), .busy_o(busy));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [16:0] calc(input logic [1:0] m, input logic [7:0] h,
                                         input logic [7:0] l, input int c);
        logic o;
        o = 1'b0;
        repeat (c)
        begin
            if (m == 2'h2)
            begin
                o = o | (l == 8'hFF);
                l = (l == 8'hFF) ? h : l + 8'h01;
            end
            else if (m == 2'h1)
            begin
                o = o | ({h, l} == 16'hFFFF);
                {h, l} = {h, l} + 16'h0001;
            end
            else
            begin
                o = o | ({h, l[4:0]} == 13'h1FFF);
                {h, l[4:0]} = {h, l[4:0]} + 13'h0001;
            end
        end
        return {o, h, l};
    endfunction
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dw <= {24'h0, d};
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 50);
        if (k >= 50)
        begin
            failures++;
            $display("[FAIL] %0t bus request not acknowledged", $time);
        end
        q = dr[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 8'h00);
    endtask
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic zr();
        wr(dmt_pkg::ADR_LOW_A, 8'h00);
        wr(dmt_pkg::ADR_HIGH_A, 8'h00);
        wr(dmt_pkg::ADR_LOW_B, 8'h00);
        wr(dmt_pkg::ADR_HIGH_B, 8'h00);
    endtask
    task automatic gpulse(input int c);
        @(posedge clk);
        ga <= 1'b1;
        gb <= 1'b1;
        repeat (c) @(posedge clk);
        ga <= 1'b0;
        gb <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    task automatic fire();
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        while (busy === 1'b1) @(posedge clk);
        repeat (8) @(posedge clk);
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        #200_000;
        failures++;
        print_verdict();
    end
    initial
    begin
        {rst, cyc, stb, we, ga, gb, vta, vtb, go} = 9'h100;
        {adr, dw, edges, hold} = 52'h0;
        seed = 32'h02c5_a085;
        failures = 0;
        total_checks = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(dmt_pkg::ADR_TCTL);
        chk({9'h0, q}, 17'h0);
        rd(8'h00);
        chk({9'h0, q}, 17'h0);
        wr(dmt_pkg::ADR_CLKCTL, 8'h0C);
        wr(dmt_pkg::ADR_EXTCFG, 8'h03);
        for (int m = 0; m < 3; m++)
            for (int j = 0; j < 3; j++)
            begin
                seed = lfsr(seed);
                {r3, r2, r1, r0} = (j == 0) ? 32'hFFFE_FFFE : seed;
                seed = lfsr(seed);
                n = 1 + seed[4:0];
                wr(dmt_pkg::ADR_LOW_A, r0);
                wr(dmt_pkg::ADR_HIGH_A, r1);
                wr(dmt_pkg::ADR_LOW_B, r2);
                wr(dmt_pkg::ADR_HIGH_B, r3);
                wr(dmt_pkg::ADR_MODE, {2'h2, 2'(m), 2'h2, 2'(m)});
                wr(dmt_pkg::ADR_TCTL, 8'h50);
                ea = calc(2'(m), r1, r0, n);
                eb = calc(2'(m), r3, r2, n);
                gpulse(n);
                msk = (m == 0) ? 8'h1F : 8'hFF;
                rd(dmt_pkg::ADR_LOW_A);
                r0 = q;
                rd(dmt_pkg::ADR_HIGH_A);
                r1 = q;
                rd(dmt_pkg::ADR_LOW_B);
                r2 = q;
                rd(dmt_pkg::ADR_HIGH_B);
                r3 = q;
                chk({fa, r1, r0 & msk}, {ea[16:8], ea[7:0] & msk});
                chk({fb, r3, r2 & msk}, {eb[16:8], eb[7:0] & msk});
            end
        $display("mode test done");
        wr(dmt_pkg::ADR_MODE, 8'h55);
        zr();
        seed = lfsr(seed);
        edges <= 8'h01 + 8'(seed[3:0]);
        hold <= 4'h2 + 4'(seed[5:4]);
        wr(dmt_pkg::ADR_TCTL, 8'h50);
        fire();
        wr(dmt_pkg::ADR_TCTL, 8'h00);
        rd(dmt_pkg::ADR_LOW_A);
        chk({9'h0, q}, {9'h0, edges});
        rd(dmt_pkg::ADR_LOW_B);
        chk({9'h0, q}, {9'h0, edges});
        $display("pin count test done");
        for (int s = 0; s < 4; s++)
        begin
            zr();
            wr(dmt_pkg::ADR_CLKCTL, 8'(s));
            wr(dmt_pkg::ADR_MODE, (s == 3) ? 8'h11 : 8'h99);
            wr(dmt_pkg::ADR_TCTL, 8'h50);
            edges <= 8'h10;
            hold <= 4'h2;
            if (s == 3)
                fire();
            else
                gpulse(96);
            wr(dmt_pkg::ADR_TCTL, 8'h00);
            n = (s == 3) ? 16 / dmt_pkg::DIV_EXT_8 : (s == 2) ? 96 / dmt_pkg::DIV_SCALE_48 :
                (s == 1) ? 96 / dmt_pkg::DIV_SCALE_4 : 96 / dmt_pkg::DIV_SCALE_12;
            rd(dmt_pkg::ADR_LOW_A);
            chk({9'h0, q}, 17'(n));
            rd(dmt_pkg::ADR_LOW_B);
            chk({9'h0, q}, 17'(n));
        end
        $display("prescale test done");
        wr(dmt_pkg::ADR_CLKCTL, 8'h0C);
        wr(dmt_pkg::ADR_HIGH_A, 8'hFF);
        wr(dmt_pkg::ADR_LOW_A, 8'hFF);
        wr(dmt_pkg::ADR_LOW_B, 8'hF0);
        wr(dmt_pkg::ADR_HIGH_B, 8'hFF);
        wr(dmt_pkg::ADR_MODE, 8'h13);
        wr(dmt_pkg::ADR_TCTL, 8'h10);
        n = 0;
        repeat (40)
        begin
            @(posedge clk);
            n += int'(pb === 1'b1);
        end
        chk({14'h0, fa, fb, n != 0}, 17'h5);
        wr(dmt_pkg::ADR_TCTL, 8'h50);
        repeat (6) @(posedge clk);
        chk({16'h0, fb}, 17'h1);
        wr(dmt_pkg::ADR_MODE, 8'h33);
        rd(dmt_pkg::ADR_LOW_B);
        r0 = q;
        repeat (20) @(posedge clk);
        rd(dmt_pkg::ADR_LOW_B);
        chk({9'h0, q}, {9'h0, r0});
        $display("split test done");
        wr(dmt_pkg::ADR_TCTL, 8'hA0);
        repeat (3) @(posedge clk);
        chk({16'h0, irq}, 17'h0);
        wr(dmt_pkg::ADR_IRQMSK, 8'h03);
        repeat (3) @(posedge clk);
        chk({16'h0, irq}, 17'h1);
        rd(dmt_pkg::ADR_IRQST);
        chk({9'h0, q}, 17'h3);
        repeat (3) @(posedge clk);
        chk({16'h0, irq}, 17'h0);
        rd(dmt_pkg::ADR_IRQST);
        chk({9'h0, q}, 17'h0);
        @(posedge clk);
        vta <= 1'b1;
        @(posedge clk);
        vta <= 1'b0;
        repeat (3) @(posedge clk);
        chk({15'h0, fa, fb}, 17'h1);
        vtb <= 1'b1;
        @(posedge clk);
        vtb <= 1'b0;
        repeat (3) @(posedge clk);
        chk({15'h0, fa, fb}, 17'h0);
        $display("interrupt test done");
        print_verdict();
    end
endmodule
`default_nettype wire
